// file: period_timer_consts.svh
`ifndef PERIOD_TIMER_CONSTS_SVH
`define PERIOD_TIMER_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_W            14
`define CTRL_IDX         14'h0f76
`define COUNT_IDX        14'h0f77
`define PERIOD_IDX       14'h0f78
`define IRQ_STAT_IDX     14'h0f79
`define IRQ_MASK_IDX     14'h0f7a

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_MATCH_DIV_HI 6
`define CTRL_MATCH_DIV_LO 3
`define CTRL_RUN_BIT      2
`define CTRL_IN_DIV_HI    1
`define CTRL_IN_DIV_LO    0
`define IRQ_PERIOD_BIT    0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RESET       7'h00
`define COUNT_RESET      8'h00
`define PERIOD_RESET     8'hff
`define IRQ_STAT_RESET   1'h0
`define IRQ_MASK_RESET   1'h0

// ----------------------------------------
// Input divider select codes and terminal counts (ratio - 1)
// ----------------------------------------
`define IN_DIV_SEL_1     2'h0
`define IN_DIV_SEL_4     2'h1
`define IN_DIV_TERM_1    4'h0
`define IN_DIV_TERM_4    4'h3
`define IN_DIV_TERM_16   4'hf

`endif

// file: period_timer_pkg.sv
package period_timer_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [3:0] match_divider_select;
    logic       counter_run;
    logic [1:0] input_divider_select;
  } ctrl_t;

  typedef struct packed {
    ctrl_t       ctrl;
    logic [7:0]  count;
    logic [7:0]  period;
    logic        stat;
    logic        mask;
    logic        match;
    logic [31:0] rdata;
    logic        slverr;
  } timer_state_t;

endpackage

// file: event_divider.sv
`timescale 1ns/10ps
`include "period_timer_consts.svh"

// Counts input events and passes every (terminal+1)-th one
module event_divider #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clear,
  input  wire logic         in_pulse,
  input  wire logic [W-1:0] terminal,
  output logic              out_pulse,
  output logic [W-1:0]      count
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Clear wins over an arriving event, so a write never lets a stale phase through
  always_comb begin
    cnt_d     = cnt_q;
    out_pulse = 1'b0;
    if (clear) begin
      cnt_d = '0;
    end else if (in_pulse) begin
      if (cnt_q >= terminal) begin
        cnt_d     = '0;
        out_pulse = 1'b1;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;

endmodule

// file: period_match_timer_8bit.sv
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`include "period_timer_consts.svh"

// Functional notes
// - Counter and period are 8-bit registers, readable and writable by software.
// - Control bit 2 runs the timer; zero stops it.
// - Prescaler on instruction clock: 00 divides 1, 01 divides 4, 1x divides 16.
// - Counter climbs from 00h to period, next increment returns 00h with match.
// - Matches pass a 1:1 to 1:16 postscaler, bits 6:3, which sets flag.
// - Counter write, control write and reset clear prescaler and postscaler.
// - Control write leaves the counter value untouched.
// - Every device reset clears the counter to zero.
// - Period register resets to FFh.
// - Raw match offered only as PWM time base, never as a baud clock.
module period_match_timer_8bit (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire period_timer_pkg::apb_req_t apb_req,
  output period_timer_pkg::apb_rsp_t     apb_rsp,
  output logic                           pwm_time_base,
  output logic                           irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  period_timer_pkg::timer_state_t st_q;
  period_timer_pkg::timer_state_t st_d;

  logic [`IDX_W-1:0] word_idx;
  logic              aligned;
  logic              setup;
  logic              access;
  logic              wr;
  logic              wr_ctrl;
  logic              wr_count;
  logic              wr_period;
  logic              wr_stat;
  logic              wr_mask;
  logic              scaler_clear;
  logic              pre_in;
  logic              pre_tick;
  logic [3:0]        pre_term;
  logic [3:0]        pre_cnt;
  logic              match;
  logic              post_tick;
  logic [3:0]        post_cnt;
  logic              mapped;
  logic [31:0]       rd_mux;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign word_idx  = apb_req.paddr[15:2];
  assign aligned   = (apb_req.paddr[1:0] == 2'h0);
  assign setup     = apb_req.psel && !apb_req.penable;
  assign access    = apb_req.psel && apb_req.penable;
  assign wr        = access && apb_req.pwrite && aligned;
  assign wr_ctrl   = wr && (word_idx == `CTRL_IDX);
  assign wr_count  = wr && (word_idx == `COUNT_IDX);
  assign wr_period = wr && (word_idx == `PERIOD_IDX);
  assign wr_stat   = wr && (word_idx == `IRQ_STAT_IDX);
  assign wr_mask   = wr && (word_idx == `IRQ_MASK_IDX);

  assign mapped = aligned && ((word_idx == `CTRL_IDX) || (word_idx == `COUNT_IDX) ||
                              (word_idx == `PERIOD_IDX) || (word_idx == `IRQ_STAT_IDX) ||
                              (word_idx == `IRQ_MASK_IDX));

  // Read data is captured in the setup cycle so prdata comes from a flop;
  // a running counter therefore reads as its value one cycle before the access phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (word_idx)
      `CTRL_IDX:     rd_mux = {25'h0, st_q.ctrl};
      `COUNT_IDX:    rd_mux = {24'h0, st_q.count};
      `PERIOD_IDX:   rd_mux = {24'h0, st_q.period};
      `IRQ_STAT_IDX: rd_mux = {31'h0, st_q.stat};
      `IRQ_MASK_IDX: rd_mux = {31'h0, st_q.mask};
      default:       rd_mux = 32'h0000_0000;
    endcase
    if (!aligned) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Prescaler and postscaler
  // ----------------------------------------
  assign scaler_clear = wr_ctrl || wr_count;

  always_comb begin
    if (st_q.ctrl.input_divider_select == `IN_DIV_SEL_1) begin
      pre_term = `IN_DIV_TERM_1;
    end else if (st_q.ctrl.input_divider_select == `IN_DIV_SEL_4) begin
      pre_term = `IN_DIV_TERM_4;
    end else begin
      pre_term = `IN_DIV_TERM_16;
    end
  end

  // The instruction clock is pclk itself; a stopped timer feeds no events
  assign pre_in = st_q.ctrl.counter_run;

  event_divider #(
    .W (4)
  ) u_input_divider (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (scaler_clear),
    .in_pulse  (pre_in),
    .terminal  (pre_term),
    .out_pulse (pre_tick),
    .count     (pre_cnt)
  );

  assign match = pre_tick && (st_q.count == st_q.period);

  event_divider #(
    .W (4)
  ) u_match_divider (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (scaler_clear),
    .in_pulse  (match),
    .terminal  (st_q.ctrl.match_divider_select),
    .out_pulse (post_tick),
    .count     (post_cnt)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.match = match;
    if (pre_tick) begin
      if (st_q.count == st_q.period) begin
        st_d.count = 8'h00;
      end else begin
        st_d.count = st_q.count + 8'h01;
      end
    end
    // A software write to the counter beats a coincident increment
    if (wr_count) begin
      st_d.count = apb_req.pwdata[7:0];
    end
    if (wr_period) begin
      st_d.period = apb_req.pwdata[7:0];
    end
    if (wr_ctrl) begin
      st_d.ctrl = apb_req.pwdata[6:0];
    end
    if (wr_mask) begin
      st_d.mask = apb_req.pwdata[`IRQ_PERIOD_BIT];
    end
    // Set beats a write-one-to-clear in the same cycle
    st_d.stat = post_tick || (st_q.stat && !(wr_stat && apb_req.pwdata[`IRQ_PERIOD_BIT]));
    if (setup) begin
      st_d.rdata  = rd_mux;
      st_d.slverr = !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.ctrl   <= `CTRL_RESET;
      st_q.count  <= `COUNT_RESET;
      st_q.period <= `PERIOD_RESET;
      st_q.stat   <= `IRQ_STAT_RESET;
      st_q.mask   <= `IRQ_MASK_RESET;
      st_q.match  <= 1'b0;
      st_q.rdata  <= 32'h0000_0000;
      st_q.slverr <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Zero-wait slave; only a PWM time base and irq leave the block, no serial baud tap
  // One driver for the whole response struct keeps it a single continuous assignment
  assign apb_rsp = '{prdata:  st_q.rdata,
                     pready:  access,
                     pslverr: access && st_q.slverr};
  assign pwm_time_base   = st_q.match;
  assign irq             = st_q.stat && st_q.mask;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic init_done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  sequence s_scaler_write;
    wr_ctrl || wr_count;
  endsequence

  sequence s_scalers_idle;
    (pre_cnt == 4'h0) && (post_cnt == 4'h0);
  endsequence

  a_reset_values: assert property (!init_done_q |-> st_q.count == 8'h00 && st_q.period == 8'hff)
    else $error("counter or period wrong after reset");

  a_period_reset: assert property (!init_done_q |-> st_q.period == 8'hff)
    else $error("period did not reset to ff");

  a_count_write: assert property (wr_count |=> st_q.count == $past(apb_req.pwdata[7:0]))
    else $error("counter write not stored");

  a_period_write: assert property (wr_period |=> st_q.period == $past(apb_req.pwdata[7:0]))
    else $error("period write not stored");

  a_stop_holds: assert property (!st_q.ctrl.counter_run && !wr_count |=> $stable(st_q.count) && !pwm_time_base)
    else $error("stopped timer moved or matched");

  a_run_counts: assert property (st_q.ctrl.counter_run && !scaler_clear && !wr_count ##0 (pre_cnt == pre_term)
                                 ##0 (st_q.count != st_q.period) |=> st_q.count == $past(st_q.count) + 8'h01)
    else $error("running timer failed to increment");

  a_prescale_ratio: assert property (pre_tick |-> (st_q.ctrl.input_divider_select == 2'h0 && pre_cnt == 4'h0) ||
                                     (st_q.ctrl.input_divider_select == 2'h1 && pre_cnt == 4'h3) ||
                                     (st_q.ctrl.input_divider_select[1] && pre_cnt == 4'hf))
    else $error("prescaler tick at wrong count");

  a_match_wrap: assert property (pre_tick && st_q.count == st_q.period && !wr_count
                                 |=> st_q.count == 8'h00 && pwm_time_base)
    else $error("match did not wrap to 00h");

  a_postscale_flag: assert property (post_tick |-> post_cnt == st_q.ctrl.match_divider_select ##1 st_q.stat)
    else $error("postscaler output did not set flag");

  a_scaler_clear: assert property (s_scaler_write |=> s_scalers_idle)
    else $error("scalers not cleared by write");

  a_ctrl_keeps_count: assert property (wr_ctrl && !wr_count |=> $stable(st_q.count))
    else $error("control write changed counter");

  a_base_only_match: assert property (pwm_time_base |-> $past(match))
    else $error("time base pulse without match");

  a_flag_sticky: assert property (st_q.stat && !(wr_stat && apb_req.pwdata[0]) |=> st_q.stat)
    else $error("flag dropped without clear");

  a_irq_gate: assert property (post_tick && st_q.mask && !wr_mask |=> irq)
    else $error("enabled flag did not raise interrupt");

  // ----------------------------------------
  // Timer checks
  // ----------------------------------------
  a_stat_clear: assert property (wr_stat && apb_req.pwdata[0] && !post_tick |=> !st_q.stat)
    else $error("flag not cleared by writing one");

  a_flag_set_wins: assert property (post_tick && wr_stat |=> st_q.stat)
    else $error("clear beat a coincident flag set");

  a_post_on_match: assert property (post_tick |-> match)
    else $error("postscaler fired without a match");

  a_match_to_base: assert property (match |=> pwm_time_base)
    else $error("match not offered as time base");

  a_stop_no_tick: assert property (!st_q.ctrl.counter_run |-> !pre_tick && !match)
    else $error("stopped timer produced a tick");

  // The counter only moves on a prescaler tick or a software write
  a_count_quiet: assert property (!pre_tick && !wr_count |=> $stable(st_q.count))
    else $error("counter moved without a tick");

  a_wrap_no_skip: assert property (pre_tick && st_q.count != st_q.period && !wr_count
                                   |=> st_q.count == $past(st_q.count) + 8'h01)
    else $error("counter skipped a value");

  sequence s_div4_tick;
    pre_tick && (st_q.ctrl.input_divider_select == 2'h1);
  endsequence

  sequence s_div4_hold;
    !wr_ctrl ##1 !wr_ctrl;
  endsequence

  // A control write may change the ratio, so only quiet stretches without one are judged
  a_div4_gap: assert property (s_div4_tick ##1 s_div4_hold |-> !pre_tick ##1 !pre_tick)
    else $error("divide-by-4 prescaler ticked early");

  // ----------------------------------------
  // Bus checks
  // ----------------------------------------
  sequence s_read_setup;
    setup && !apb_req.pwrite;
  endsequence

  sequence s_read_access;
    access && !apb_req.pwrite;
  endsequence

  a_read_data: assert property (s_read_setup ##1 s_read_access |-> apb_rsp.prdata == $past(rd_mux))
    else $error("read data not taken at the setup edge");

  a_mapped_ok: assert property (setup && mapped ##1 access |-> apb_rsp.pready && !apb_rsp.pslverr)
    else $error("mapped register refused");

  a_unmapped_err: assert property (setup && !mapped ##1 access |-> apb_rsp.pslverr
                                   && apb_rsp.prdata == 32'h0000_0000)
    else $error("unmapped address not refused");

  a_refused_write: assert property (wr && !mapped |=> $stable(st_q.ctrl) && $stable(st_q.period)
                                    && $stable(st_q.mask))
    else $error("write to unmapped address landed");

  a_ctrl_write: assert property (wr_ctrl |=> st_q.ctrl == $past(apb_req.pwdata[6:0]))
    else $error("control write not stored");

  a_ctrl_only_write: assert property (!wr_ctrl |=> $stable(st_q.ctrl))
    else $error("control changed without a write");

  a_period_only_write: assert property (!wr_period |=> $stable(st_q.period))
    else $error("period changed without a write");

  a_mask_write: assert property (wr_mask |=> st_q.mask == $past(apb_req.pwdata[0]))
    else $error("enable write not stored");

  a_mask_only_write: assert property (!wr_mask |=> $stable(st_q.mask))
    else $error("enable changed without a write");

endmodule

// file: pwm_user.sv
`timescale 1ns/10ps

// ----------------------------------------
// Time base user on the far side
// ----------------------------------------
module pwm_user (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic time_base,
  output int        n_pulse,
  output int        gap_last
);
  int cnt_q;

  // Restarts its duty period on each raw match and never takes it as a baud clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_pulse  <= 0;
      gap_last <= 0;
      cnt_q    <= 0;
    end else if (time_base) begin
      n_pulse  <= n_pulse + 1;
      gap_last <= cnt_q + 1;
      cnt_q    <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

// file: testbench.sv
`timescale 1ns/10ps
`include "period_timer_consts.svh"

module testbench;
  period_timer_pkg::apb_req_t req;
  period_timer_pkg::apb_rsp_t rsp;
  logic                       pclk;
  logic                       presetn;
  logic                       pwm_time_base;
  logic                       irq;
  logic [32:0]                rq[$];
  logic [31:0]                lfsr;
  logic [31:0]                v;
  int                         n_fail = 0;
  int                         samples_checked = 0;
  int                         cyc = 0;
  int                         ratio[4] = '{1, 4, 16, 16};
  int                         p;
  int                         s;

  period_match_timer_8bit u_dut (
    .pclk          (pclk),
    .presetn       (presetn),
    .apb_req       (req),
    .apb_rsp       (rsp),
    .pwm_time_base (pwm_time_base),
    .irq           (irq)
  );

  pwm_user pm (
    .pclk      (pclk),
    .presetn   (presetn),
    .time_base (pwm_time_base),
    .n_pulse   (),
    .gap_last  ()
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] step_lfsr();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
    return lfsr;
  endfunction

  task automatic check(input string nm, input logic [32:0] e, input logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  // Reads note their expectation; the monitor below does the compare
  task automatic xfer(input logic w, input logic [13:0] ix, input logic [31:0] d, input logic [32:0] e);
    if (!w) rq.push_back(e);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {ix, 2'b00}, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // Waits for pready with no limit of its own; only the bench timeout ends a hung wait
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wait_pulses(input int k);
    int b;
    b = pm.n_pulse;
    while (pm.n_pulse < b + k) @(posedge pclk);
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, monitor, timeout
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
      check("read", rq.pop_front(), {rsp.pslverr, rsp.prdata});
    end
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    req     = '0;
    presetn = 1'b0;
    lfsr    = 32'hd07c;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1, 14'h0f7b, 32'hffff_ffff, 0);
    xfer(0, `CTRL_IDX, 0, 33'h0);
    xfer(0, `COUNT_IDX, 0, 33'h0);
    xfer(0, `PERIOD_IDX, 0, 33'hff);
    xfer(0, `IRQ_STAT_IDX, 0, 33'h0);
    xfer(0, 14'h0f7b, 0, 33'h1_0000_0000);
    done("reset");
    v = step_lfsr();
    xfer(1, `COUNT_IDX, v, 0);
    xfer(1, `CTRL_IDX, 32'hffff_fffb, 0);
    xfer(1, `PERIOD_IDX, {v[15:8], v[31:8]}, 0);
    repeat (20) @(posedge pclk);
    xfer(0, `COUNT_IDX, 0, {25'h0, v[7:0]});
    xfer(0, `CTRL_IDX, 0, 33'h7b);
    xfer(0, `PERIOD_IDX, 0, {25'h0, v[15:8]});
    done("hold");
    for (int k = 0; k < 4; k++) begin
      v = step_lfsr();
      p = v[2:0] + 1;
      xfer(1, `CTRL_IDX, 0, 0);
      xfer(1, `COUNT_IDX, 0, 0);
      xfer(1, `PERIOD_IDX, 32'(p), 0);
      xfer(1, `CTRL_IDX, 32'(4 + k), 0);
      wait_pulses(3);
      check("gap", 33'((p + 1) * ratio[k]), 33'(pm.gap_last));
    end
    done("divide");
    xfer(1, `CTRL_IDX, 0, 0);
    xfer(1, `COUNT_IDX, 0, 0);
    xfer(1, `PERIOD_IDX, 7, 0);
    xfer(1, `IRQ_MASK_IDX, 1, 0);
    xfer(1, `IRQ_STAT_IDX, 1, 0);
    xfer(1, `CTRL_IDX, 32'h1c, 0);
    wait_pulses(2);
    xfer(1, `CTRL_IDX, 32'h1c, 0);
    s = pm.n_pulse;
    for (int i = 0; i < 500 && irq !== 1'b1; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    check("matches", 33'h4, 33'(pm.n_pulse - s));
    check("irq", 33'h1, {32'h0, irq});
    xfer(1, `IRQ_MASK_IDX, 0, 0);
    repeat (2) @(posedge pclk);
    check("irq", 33'h0, {32'h0, irq});
    xfer(0, `IRQ_STAT_IDX, 0, 33'h1);
    xfer(1, `CTRL_IDX, 0, 0);
    xfer(1, `IRQ_STAT_IDX, 1, 0);
    xfer(1, `IRQ_MASK_IDX, 1, 0);
    s = pm.n_pulse;
    repeat (100) @(posedge pclk);
    check("irq", 33'h0, {32'h0, irq});
    check("stopped", 33'h0, 33'(pm.n_pulse - s));
    xfer(0, `IRQ_STAT_IDX, 0, 33'h0);
    done("irq");
    xfer(1, `PERIOD_IDX, 32'h40, 0);
    xfer(1, `COUNT_IDX, v, 0);
    xfer(1, `CTRL_IDX, 32'h4, 0);
    repeat (10) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, `COUNT_IDX, 0, 33'h0);
    xfer(0, `PERIOD_IDX, 0, 33'hff);
    xfer(0, `CTRL_IDX, 0, 33'h0);
    done("reset again");
    repeat (3) @(posedge pclk);
    close_out();
  end
endmodule
